//--- logic/can_txbrc_pkg.sv
// shared constants, register map and types of the tx request control block
`default_nettype none
package can_txbrc_pkg;

	localparam int NUM_BUF = 32;
	localparam int IDX_W = 5;
	localparam int ID_W = 29;
	localparam int ADDR_W = 12;

	// register byte offsets
	localparam logic [ADDR_W-1:0] OFF_BUFFER_CONFIG = 12'h0c0;
	localparam logic [ADDR_W-1:0] OFF_FIFO_QUEUE_STATE = 12'h0c4;
	localparam logic [ADDR_W-1:0] OFF_ELEMENT_SIZE = 12'h0c8;
	localparam logic [ADDR_W-1:0] OFF_PENDING = 12'h0cc;
	localparam logic [ADDR_W-1:0] OFF_ADD = 12'h0d0;
	localparam logic [ADDR_W-1:0] OFF_CANCEL = 12'h0d4;
	localparam logic [ADDR_W-1:0] OFF_OCCURRED = 12'h0d8;
	localparam logic [ADDR_W-1:0] OFF_FINISHED = 12'h0dc;
	localparam logic [ADDR_W-1:0] OFF_CONTROL = 12'h0e8;

	// field positions
	localparam int QUEUE_MODE_BIT = 30;
	localparam int FIFO_SIZE_LSB = 24;
	localparam int DEDICATED_LSB = 16;
	localparam int PUT_INDEX_LSB = 16;
	localparam int GET_INDEX_LSB = 8;
	localparam int FREE_LEVEL_LSB = 0;
	localparam int DATA_SIZE_LSB = 0;
	localparam int NO_AUTO_RETX_BIT = 0;

	// values after reset
	localparam logic [31:0] BITS_RESET = 32'h0000_0000;
	localparam logic [2:0] DATA_SIZE_RESET = 3'h0;
	localparam logic [7:0] PAD_BYTE = 8'hcc;

	localparam logic [5:0] MAX_BUF = 6'h20;

	typedef struct packed {
		logic queue_mode_select;
		logic [5:0] fifo_size;
		logic [5:0] dedicated_count;
	} tx_buffer_config_t;

	localparam tx_buffer_config_t BUFFER_CONFIG_RESET = 13'h0000;

	// end of a transmission reported by the protocol engine
	typedef struct packed {
		logic done;
		logic success;
	} tx_result_t;

	typedef enum logic [1:0] {
		SCAN_IDLE = 2'b00,
		SCAN_RUN = 2'b01,
		SCAN_DONE = 2'b11
	} scan_state_t;

	function automatic logic [6:0] data_field_bytes(input logic [2:0] code);
		case (code)
			3'h0: return 7'h08;
			3'h1: return 7'h0c;
			3'h2: return 7'h10;
			3'h3: return 7'h14;
			3'h4: return 7'h18;
			3'h5: return 7'h20;
			3'h6: return 7'h30;
			default: return 7'h40;
		endcase
	endfunction

	function automatic logic [5:0] clamp_count(input logic [5:0] v);
		return (v > MAX_BUF) ? MAX_BUF : v;
	endfunction

endpackage
`default_nettype wire

//--- logic/can_tx_scan.sv
// tx scan: walks a snapshot of eligible buffers, keeps the lowest identifier
`timescale 1ns/1ps
`default_nettype none
module can_tx_scan #(
	parameter int NUM_BUF = can_txbrc_pkg::NUM_BUF,
	parameter int IDX_W = can_txbrc_pkg::IDX_W,
	parameter int ID_W = can_txbrc_pkg::ID_W
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// control
	input wire logic start,
	input wire logic [NUM_BUF-1:0] eligible,
	// identifier lookup
	output logic [IDX_W-1:0] id_addr,
	input wire logic [ID_W-1:0] id_value,
	// result
	output logic busy,
	output logic done,
	output logic found,
	output logic [IDX_W-1:0] best_index
);

	can_txbrc_pkg::scan_state_t state;
	logic [NUM_BUF-1:0] snap;
	logic [ID_W-1:0] best_id;

	assign busy = (state != can_txbrc_pkg::SCAN_IDLE);
	assign done = (state == can_txbrc_pkg::SCAN_DONE);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= can_txbrc_pkg::SCAN_IDLE;
		end else begin
			case (state)
				can_txbrc_pkg::SCAN_IDLE: begin
					if (start) begin
						state <= can_txbrc_pkg::SCAN_RUN;
					end
				end
				can_txbrc_pkg::SCAN_RUN: begin
					if (id_addr == IDX_W'(NUM_BUF - 1)) begin
						state <= can_txbrc_pkg::SCAN_DONE;
					end
				end
				default: state <= can_txbrc_pkg::SCAN_IDLE;
			endcase
		end
	end

	// late arrivals stay out of the snapshot until the next scan
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			snap <= '0;
			id_addr <= '0;
		end else if (state == can_txbrc_pkg::SCAN_IDLE && start) begin
			snap <= eligible;
			id_addr <= '0;
		end else if (state == can_txbrc_pkg::SCAN_RUN) begin
			id_addr <= id_addr + IDX_W'(1);
		end
	end

	// strict compare: on equal identifiers the lower buffer number wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			found <= 1'b0;
			best_index <= '0;
			best_id <= '0;
		end else if (state == can_txbrc_pkg::SCAN_IDLE && start) begin
			found <= 1'b0;
		end else if (state == can_txbrc_pkg::SCAN_RUN && snap[id_addr]) begin
			if (!found || id_value < best_id) begin
				found <= 1'b1;
				best_index <= id_addr;
				best_id <= id_value;
			end
		end
	end

endmodule
`default_nettype wire

//--- logic/can_tx_buffer_request_control.sv
// tx buffer request control: apb registers, request bits, scan and padding
//
// Overview of operation
// - put index reported in bits 20 to 16
// - get index bits 12 to 8, zero in queue
// - free level bits 5 to 0, zero in queue
// - indices are absolute buffer numbers
// - three-bit code selects data field size
// - bytes beyond data field sent as 0xCC
// - pending bit per buffer, set by add
// - only configured buffers can be set
// - newly pending bit starts a tx scan
// - lowest identifier wins the scan
// - started transmission cancels at its end
// - cancel bit clears right after pending clears
// - cancel finished on all four outcomes, except a cancel written in the cycle a send succeeds
// - no auto retransmit cancels failed sends
// - scan ignores late bits, cancel clears them
// - add register is write one to set
// - add bits held only while scan runs
// - add on pending buffer is ignored
// - cancel register is write one to set
// - occurred set on success, cleared by add
// - finished set on cancel, cleared by add
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module can_tx_buffer_request_control #(
	parameter int ID_W = can_txbrc_pkg::ID_W
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic [can_txbrc_pkg::ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// identifier lookup for the scan
	output logic [can_txbrc_pkg::IDX_W-1:0] id_addr,
	input wire logic [ID_W-1:0] id_value,
	// protocol engine request and result
	output logic tx_req,
	output logic [can_txbrc_pkg::IDX_W-1:0] tx_index,
	output logic [6:0] tx_field_bytes,
	input wire logic tx_started,
	input wire can_txbrc_pkg::tx_result_t tx_result,
	// data byte path with padding
	input wire logic [5:0] byte_index,
	input wire logic [7:0] ram_byte,
	output logic [7:0] tx_byte
);

	localparam int NB = can_txbrc_pkg::NUM_BUF;
	localparam int IW = can_txbrc_pkg::IDX_W;

	can_txbrc_pkg::tx_buffer_config_t buf_cfg;
	logic [2:0] tx_data_field_size;
	logic no_auto_retransmit_mode;
	logic [NB-1:0] pending_bits, add_bits, cancel_bits;
	logic [NB-1:0] occurred_bits, finished_bits;
	logic [NB-1:0] next_pending, next_add, next_cancel;
	logic [NB-1:0] next_occurred, next_finished;
	logic [NB-1:0] configured, in_fifo, eligible;
	logic [NB-1:0] add_write, cancel_write, started_mask, done_mask;
	logic [IW-1:0] get_index, scan_best;
	logic active, scan_needed, scan_start, scan_busy, scan_done, scan_found;
	logic [5:0] first_fifo, free_level;
	logic [6:0] total_bufs, fifo_size_eff, fifo_count;
	logic [4:0] put_index;
	logic [31:0] wmask, wbits, rdata;
	logic mapped, apb_access, write_fire;
	////////////////////////////////////////////////////////////////////////
	// configuration decode
	assign first_fifo = can_txbrc_pkg::clamp_count(buf_cfg.dedicated_count);
	always_comb begin
		total_bufs = 7'(first_fifo) +
			7'(can_txbrc_pkg::clamp_count(buf_cfg.fifo_size));
		if (total_bufs > 7'(can_txbrc_pkg::MAX_BUF)) begin
			total_bufs = 7'(can_txbrc_pkg::MAX_BUF);
		end
		fifo_size_eff = total_bufs - 7'(first_fifo);
	end

	// in fifo mode only dedicated buffers and the fifo element at the get index may compete
	genvar gi;
	generate
		for (gi = 0; gi < NB; gi++) begin : g_mask
			assign configured[gi] = 7'(gi) < total_bufs;
			assign in_fifo[gi] = (6'(gi) >= first_fifo) && configured[gi];
			assign eligible[gi] = pending_bits[gi] &
				(~in_fifo[gi] | buf_cfg.queue_mode_select |
				(IW'(gi) == get_index));
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// fifo / queue status
	always_comb begin
		logic [6:0] offs;
		offs = '0;
		fifo_count = '0;
		put_index = '0;
		free_level = '0;
		for (int i = 0; i < NB; i++) begin
			if (pending_bits[i] && in_fifo[i]) begin
				fifo_count = fifo_count + 7'(1);
			end
		end
		if (buf_cfg.queue_mode_select) begin
			// lowest free queue slot, absolute number
			for (int i = NB - 1; i >= 0; i--) begin
				if (in_fifo[i] && !pending_bits[i] && !add_bits[i]) begin
					put_index = 5'(i);
				end
			end
		end else if (fifo_size_eff != 7'(0)) begin
			offs = 7'(get_index) - 7'(first_fifo) + fifo_count;
			if (offs >= fifo_size_eff) begin
				offs = offs - fifo_size_eff;
			end
			put_index = 5'(7'(first_fifo) + offs);
			free_level = 6'(fifo_size_eff - fifo_count);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// apb slave: one wait state so read data comes from a flop
	assign apb_access = psel & penable;
	assign write_fire = apb_access & pready & pwrite & mapped;
	assign wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}},
		{8{pstrb[0]}}};
	assign wbits = pwdata & wmask;

	always_comb begin
		mapped = 1'b1;
		rdata = 32'h0000_0000;
		case (paddr)
			can_txbrc_pkg::OFF_BUFFER_CONFIG: begin
				rdata[can_txbrc_pkg::QUEUE_MODE_BIT] =
					buf_cfg.queue_mode_select;
				rdata[can_txbrc_pkg::FIFO_SIZE_LSB +: 6] = buf_cfg.fifo_size;
				rdata[can_txbrc_pkg::DEDICATED_LSB +: 6] =
					buf_cfg.dedicated_count;
			end
			can_txbrc_pkg::OFF_FIFO_QUEUE_STATE: begin
				rdata[can_txbrc_pkg::PUT_INDEX_LSB +: 5] = put_index;
				if (!buf_cfg.queue_mode_select) begin
					rdata[can_txbrc_pkg::GET_INDEX_LSB +: 5] = get_index;
					rdata[can_txbrc_pkg::FREE_LEVEL_LSB +: 6] = free_level;
				end
			end
			can_txbrc_pkg::OFF_ELEMENT_SIZE:
				rdata[can_txbrc_pkg::DATA_SIZE_LSB +: 3] = tx_data_field_size;
			can_txbrc_pkg::OFF_PENDING: rdata = pending_bits;
			can_txbrc_pkg::OFF_ADD: rdata = add_bits;
			can_txbrc_pkg::OFF_CANCEL: rdata = cancel_bits;
			can_txbrc_pkg::OFF_OCCURRED: rdata = occurred_bits;
			can_txbrc_pkg::OFF_FINISHED: rdata = finished_bits;
			can_txbrc_pkg::OFF_CONTROL:
				rdata[can_txbrc_pkg::NO_AUTO_RETX_BIT] = no_auto_retransmit_mode;
			default: mapped = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else if (apb_access && !pready) begin
			pready <= 1'b1;
			pslverr <= ~mapped;
			prdata <= pwrite ? 32'h0000_0000 : rdata;
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end
	end

	// configuration writes honour byte lanes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			buf_cfg <= can_txbrc_pkg::BUFFER_CONFIG_RESET;
			tx_data_field_size <= can_txbrc_pkg::DATA_SIZE_RESET;
			no_auto_retransmit_mode <= 1'b0;
		end else if (write_fire) begin
			if (paddr == can_txbrc_pkg::OFF_BUFFER_CONFIG) begin
				if (pstrb[3]) begin
					buf_cfg.queue_mode_select <=
						pwdata[can_txbrc_pkg::QUEUE_MODE_BIT];
					buf_cfg.fifo_size <= pwdata[can_txbrc_pkg::FIFO_SIZE_LSB +: 6];
				end
				if (pstrb[2]) begin
					buf_cfg.dedicated_count <=
						pwdata[can_txbrc_pkg::DEDICATED_LSB +: 6];
				end
			end
			if (paddr == can_txbrc_pkg::OFF_ELEMENT_SIZE && pstrb[0]) begin
				tx_data_field_size <= pwdata[can_txbrc_pkg::DATA_SIZE_LSB +: 3];
			end
			if (paddr == can_txbrc_pkg::OFF_CONTROL && pstrb[0]) begin
				no_auto_retransmit_mode <=
					pwdata[can_txbrc_pkg::NO_AUTO_RETX_BIT];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// request bit vectors
	always_comb begin
		add_write = '0;
		cancel_write = '0;
		if (write_fire && paddr == can_txbrc_pkg::OFF_ADD) begin
			add_write = wbits & configured & ~pending_bits;
		end
		if (write_fire && paddr == can_txbrc_pkg::OFF_CANCEL) begin
			cancel_write = wbits & configured;
		end
		started_mask = '0;
		if (active || (tx_req && tx_started)) begin
			started_mask = NB'(1) << tx_index;
		end
		done_mask = '0;
		if (active && tx_result.done) begin
			done_mask = NB'(1) << tx_index;
		end
	end

	always_comb begin
		next_pending = pending_bits;
		next_occurred = occurred_bits & ~add_write;
		next_finished = finished_bits & ~add_write;
		// a not yet started buffer, late arrivals included, leaves at once
		next_pending = next_pending & ~(cancel_bits & ~started_mask);
		next_finished = next_finished |
			(cancel_bits & pending_bits & ~started_mask);
		if (tx_result.success) begin
			next_pending = next_pending & ~done_mask;
			next_occurred = next_occurred | done_mask;
			next_finished = next_finished | (done_mask & cancel_bits);
		end else if (no_auto_retransmit_mode ||
			|(done_mask & cancel_bits)) begin
			next_pending = next_pending & ~done_mask;
			next_finished = next_finished | done_mask;
		end
		// cancel of a buffer not pending finishes immediately
		next_finished = next_finished | (cancel_write & ~pending_bits);
		if (!scan_busy) begin
			next_pending = next_pending | add_bits;
		end
		next_add = ((scan_busy ? add_bits : '0) | add_write) &
			~cancel_write;
		// cancel bit drops one cycle after its pending bit is gone
		next_cancel = (cancel_bits & pending_bits) |
			(cancel_write & pending_bits);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pending_bits <= can_txbrc_pkg::BITS_RESET;
			add_bits <= can_txbrc_pkg::BITS_RESET;
			cancel_bits <= can_txbrc_pkg::BITS_RESET;
			occurred_bits <= can_txbrc_pkg::BITS_RESET;
			finished_bits <= can_txbrc_pkg::BITS_RESET;
		end else begin
			pending_bits <= next_pending;
			add_bits <= next_add;
			cancel_bits <= next_cancel;
			occurred_bits <= next_occurred;
			finished_bits <= next_finished;
		end
	end

	// get index follows the fifo element that leaves the pending set
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			get_index <= '0;
		end else if (write_fire && paddr == can_txbrc_pkg::OFF_BUFFER_CONFIG) begin
			get_index <= IW'(can_txbrc_pkg::clamp_count(
				pwdata[can_txbrc_pkg::DEDICATED_LSB +: 6]));
		end else if (in_fifo[get_index] && pending_bits[get_index] &&
			!next_pending[get_index]) begin
			if (7'(get_index) + 7'(1) >= total_bufs) begin
				get_index <= IW'(first_fifo);
			end else begin
				get_index <= get_index + IW'(1);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// scan scheduling and engine request
	// one scan at a time, and none while a frame is on its way out
	assign scan_start = scan_needed && !scan_busy && !tx_req && !active;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scan_needed <= 1'b0;
		end else if ((!scan_busy && |add_bits) || tx_result.done ||
			(tx_req && !pending_bits[tx_index])) begin
			scan_needed <= 1'b1;
		end else if (scan_start) begin
			scan_needed <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_req <= 1'b0;
			tx_index <= '0;
			active <= 1'b0;
		end else if (active) begin
			if (tx_result.done) begin
				active <= 1'b0;
			end
		end else if (tx_req) begin
			if (tx_started) begin
				tx_req <= 1'b0;
				active <= 1'b1;
			end else if (!pending_bits[tx_index]) begin
				tx_req <= 1'b0;
			end
		end else if (scan_done && scan_found && pending_bits[scan_best]) begin
			tx_req <= 1'b1;
			tx_index <= scan_best;
		end
	end

	can_tx_scan #(
		.NUM_BUF(NB),
		.IDX_W(IW),
		.ID_W(ID_W)
	) u_scan (
		.pclk(pclk),
		.presetn(presetn),
		.start(scan_start),
		.eligible(eligible),
		.id_addr(id_addr),
		.id_value(id_value),
		.busy(scan_busy),
		.done(scan_done),
		.found(scan_found),
		.best_index(scan_best)
	);

	////////////////////////////////////////////////////////////////////////
	// data field size and padding
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_field_bytes <= 7'h08;
			tx_byte <= can_txbrc_pkg::PAD_BYTE;
		end else begin
			tx_field_bytes <= can_txbrc_pkg::data_field_bytes(
				tx_data_field_size);
			tx_byte <= (7'(byte_index) < tx_field_bytes) ? ram_byte :
				can_txbrc_pkg::PAD_BYTE;
		end
	end

endmodule
`default_nettype wire

//--- verification/can_txbrc_properties.sv
// checker for the tx request control block ports, bound to its top
`timescale 1ns/1ps
`default_nettype none
module can_txbrc_properties (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic [can_txbrc_pkg::ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// engine side
	input wire logic tx_req,
	input wire logic [can_txbrc_pkg::IDX_W-1:0] tx_index,
	input wire logic tx_started,
	input wire logic [6:0] tx_field_bytes,
	// byte path
	input wire logic [5:0] byte_index,
	input wire logic [7:0] ram_byte,
	input wire logic [7:0] tx_byte
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic queue_q;
	logic [2:0] code_q;
	logic cfg_wr;
	logic size_wr;
	function automatic logic [6:0] size_of(input logic [2:0] c);
		return c < 5 ? 7'(8 + 4 * c) :
			(c == 5 ? 7'h20 : (c == 6 ? 7'h30 : 7'h40));
	endfunction
	assign cfg_wr = psel && penable && pready && pwrite &&
		paddr == can_txbrc_pkg::OFF_BUFFER_CONFIG && pstrb[3];
	assign size_wr = psel && penable && pready && pwrite &&
		paddr == can_txbrc_pkg::OFF_ELEMENT_SIZE && pstrb[0];
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) queue_q <= 1'b0;
		else if (cfg_wr) queue_q <= pwdata[30];
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) code_q <= 3'h0;
		else if (size_wr) code_q <= pwdata[2:0];
	end
	sequence apb_end;
		psel && penable && pready;
	endsequence
	////////////////////////////////////////////////////////////
	pready_wait_a: assert property (psel && penable && !pready |=>
		pready ##1 !pready)
		else $error("apb answer not one cycle after access");
	read_idle_a: assert property (!pready |-> prdata == 32'h0000_0000)
		else $error("read data outside answer cycle");
	slverr_pair_a: assert property (pslverr |-> pready)
		else $error("error flag without ready");
	pad_byte_a: assert property (1'b1 |=> tx_byte == ($past(byte_index) <
		$past(tx_field_bytes) ? $past(ram_byte) : 8'hcc))
		else $error("byte path or padding wrong");
	field_size_a: assert property (size_wr |-> ##[1:2]
		tx_field_bytes == size_of(code_q))
		else $error("data field size mismatch");
	queue_state_a: assert property (apb_end ##0 (!pwrite && queue_q &&
		paddr == can_txbrc_pkg::OFF_FIFO_QUEUE_STATE) |-> prdata[12:0] == 13'h0000)
		else $error("get index or free level nonzero in queue mode");
	req_hold_a: assert property (tx_req && $past(tx_req) |->
		$stable(tx_index))
		else $error("selected buffer changed under request");
	req_drop_a: assert property (tx_req && tx_started |=> !tx_req)
		else $error("request held after engine took it");
endmodule
bind can_tx_buffer_request_control can_txbrc_properties i_props (.pclk(pclk),
	.presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
	.pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .tx_req(tx_req), .tx_index(tx_index),
	.tx_started(tx_started), .tx_field_bytes(tx_field_bytes),
	.byte_index(byte_index), .ram_byte(ram_byte), .tx_byte(tx_byte));
`default_nettype wire

//--- verification/can_engine_model.sv
// protocol engine model with identifier table
`timescale 1ns/1ps
`default_nettype none
module can_engine_model #(
	parameter int FRAME = 40
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// identifier lookup
	input wire logic [can_txbrc_pkg::IDX_W-1:0] id_addr,
	output logic [can_txbrc_pkg::ID_W-1:0] id_value,
	// request, latency, outcome
	input wire logic tx_req,
	input wire logic [3:0] lat,
	input wire logic ok,
	output logic tx_started,
	output var can_txbrc_pkg::tx_result_t tx_result
);
	logic [can_txbrc_pkg::ID_W-1:0] ids [32];
	logic busy;
	int cnt;
	assign id_value = ids[id_addr];
	// success is only meaningful with done, so it idles at the wrong level
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy <= 1'b0;
			cnt <= 0;
			tx_started <= 1'b0;
			tx_result <= '0;
		end else begin
			tx_started <= 1'b0;
			tx_result <= {1'b0, !ok};
			if (busy) begin
				cnt <= cnt + 1;
				if (cnt == FRAME) begin
					tx_result <= {1'b1, ok};
					busy <= 1'b0;
					cnt <= 0;
				end
			end else if (tx_req && !tx_started) begin
				cnt <= cnt + 1;
				if (cnt >= int'(lat)) begin
					tx_started <= 1'b1;
					busy <= 1'b1;
					cnt <= 0;
				end
			end else begin
				cnt <= 0;
			end
		end
	end
endmodule
`default_nettype wire

//--- verification/can_tx_buffer_request_control_tb.sv
// self-checking testbench of the tx buffer request control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, x) begin num_checks++; if ((g) !== (x)) begin n_errors++; \
	$display("ERROR %0t: got %h expected %h", $time, g, x); end end
module can_tx_buffer_request_control_tb;
	localparam logic [11:0] R_PEND = can_txbrc_pkg::OFF_PENDING;
	localparam logic [11:0] R_ADD = can_txbrc_pkg::OFF_ADD;
	localparam logic [11:0] R_CAN = can_txbrc_pkg::OFF_CANCEL;
	localparam logic [11:0] R_OCC = can_txbrc_pkg::OFF_OCCURRED;
	localparam logic [11:0] R_FIN = can_txbrc_pkg::OFF_FINISHED;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e, ok;
	logic tx_req, tx_started;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [3:0] pstrb, lat;
	logic [4:0] id_addr, tx_index;
	logic [28:0] id_value;
	logic [6:0] tx_field_bytes;
	logic [5:0] byte_index, bi;
	logic [7:0] ram_byte, tx_byte, rb;
	can_txbrc_pkg::tx_result_t tx_result;
	int n_errors, num_checks, seed, k, c, j;
	can_tx_buffer_request_control i_dut (.pclk(pclk), .presetn(presetn),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .id_addr(id_addr), .id_value(id_value),
		.tx_req(tx_req), .tx_index(tx_index), .tx_field_bytes(tx_field_bytes),
		.tx_started(tx_started), .tx_result(tx_result),
		.byte_index(byte_index), .ram_byte(ram_byte), .tx_byte(tx_byte));
	can_engine_model i_eng (.pclk(pclk), .presetn(presetn), .id_addr(id_addr),
		.id_value(id_value), .tx_req(tx_req), .lat(lat), .ok(ok),
		.tx_started(tx_started), .tx_result(tx_result));
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	////////////////////////////////////////////////////////////
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// request held until ready is seen high at a rising edge
	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
		int t;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		t = 0;
		// values read here are those standing just before this edge
		do begin @(posedge pclk); t++; end while (pready !== 1'b1 && t < 20);
		if (t >= 20) begin n_errors++; tally_and_finish(); end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] x);
		apb(a, 1'b0, '0);
		`CHK(r, x)
	endtask
	task automatic poll(input logic [11:0] a, input logic [31:0] x);
		int t;
		for (t = 0; t < 300; t++) begin
			apb(a, 1'b0, '0);
			if (r === x) break;
		end
		`CHK(r, x)
		if (t == 300) tally_and_finish();
	endtask
	task automatic wait_on(input logic which);
		for (k = 0; k < 300 && (which ? tx_started : tx_req) !== 1'b1; k++)
			@(negedge pclk);
		`CHK(which ? tx_started : tx_req, 1'b1)
		if (k == 300) tally_and_finish();
	endtask
	function automatic logic [6:0] fb(input int c);
		return c < 5 ? 7'(8 + 4 * c) : (c == 5 ? 7'h20 : (c == 6 ? 7'h30 : 7'h40));
	endfunction
	////////////////////////////////////////////////////////////
	initial begin
		seed = 37872;
		n_errors = 0;
		num_checks = 0;
		{presetn, psel, penable, pwrite, ok, lat} = '0;
		{paddr, pwdata, byte_index, ram_byte} = '0;
		pstrb = 4'hf;
		ok = 1'b1;
		for (k = 0; k < 32; k++) i_eng.ids[k] = 29'($random(seed));
		i_eng.ids[1] = 29'h0000_0032;
		i_eng.ids[2] = 29'h0000_000a;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		for (k = 0; k < 5; k++) rdc(12'(R_PEND + 4 * k), '0);
		apb(12'h0f0, 1'b0, '0);
		`CHK(e, 1'b1)
		$display("test reset and map done");
		for (c = 0; c < 8; c++) begin
			apb(can_txbrc_pkg::OFF_ELEMENT_SIZE, 1'b1, 32'(c));
			repeat (2) @(negedge pclk);
			`CHK(tx_field_bytes, fb(c))
			for (j = 0; j < 4; j++) begin
				@(posedge pclk);
				bi = j < 2 ? 6'(fb(c) - 1 + j) : 6'($random(seed));
				rb = 8'($random(seed));
				byte_index <= bi;
				ram_byte <= rb;
				lat <= 4'($random(seed));
				@(posedge pclk);
				@(negedge pclk);
				`CHK(tx_byte, 7'(bi) < fb(c) ? rb : 8'hcc)
			end
		end
		$display("test sizes and padding done");
		apb(can_txbrc_pkg::OFF_BUFFER_CONFIG, 1'b1, 32'h4404_0000);
		rdc(can_txbrc_pkg::OFF_FIFO_QUEUE_STATE, 32'h0004_0000);
		apb(R_ADD, 1'b1, 32'h0010_0006);
		rdc(R_ADD, '0);
		rdc(R_PEND, 32'h0000_0006);
		wait_on(1'b0);
		`CHK(tx_index, 5'h02)
		poll(R_PEND, 32'h0000_0002);
		rdc(R_OCC, 32'h0000_0004);
		$display("test add and send done");
		wait_on(1'b1);
		apb(R_CAN, 1'b1, 32'h0000_0002);
		rdc(R_PEND, 32'h0000_0002);
		rdc(R_CAN, 32'h0000_0002);
		poll(R_PEND, '0);
		rdc(R_CAN, '0);
		rdc(R_FIN, 32'h0000_0002);
		rdc(R_OCC, 32'h0000_0006);
		apb(R_CAN, 1'b1, 32'h0000_0008);
		rdc(R_FIN, 32'h0000_000a);
		apb(R_ADD, 1'b1, 32'h0000_0004);
		apb(R_CAN, 1'b1, 32'h0000_0004);
		rdc(R_PEND, '0);
		rdc(R_FIN, 32'h0000_000e);
		rdc(R_OCC, 32'h0000_0002);
		$display("test cancel done");
		apb(can_txbrc_pkg::OFF_CONTROL, 1'b1, 32'h0000_0001);
		ok <= 1'b0;
		apb(R_ADD, 1'b1, 32'h0000_000e);
		rdc(R_FIN, '0);
		rdc(R_OCC, '0);
		poll(R_PEND, '0);
		rdc(R_FIN, 32'h0000_000e);
		$display("test no retransmit done");
		// second reset in mid-run, then fifo indices from a known state
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rdc(R_FIN, '0);
		apb(can_txbrc_pkg::OFF_BUFFER_CONFIG, 1'b1, 32'h0404_0000);
		rdc(can_txbrc_pkg::OFF_FIFO_QUEUE_STATE, 32'h0004_0404);
		apb(R_ADD, 1'b1, 32'h0000_0010);
		rdc(can_txbrc_pkg::OFF_FIFO_QUEUE_STATE, 32'h0005_0403);
		$display("test reset and fifo done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
